/* File: cscf_defs.svh */
// How it works
// - Zero count, no drop chars: store everything
// - Sync-on-idles acquires sync from idle pattern
// - Idle character defaults to all ones
// - Idles stored only with no drop; idle drop returns hunting
// - Bit slip refused for MSB-first data
// - Bit slip never crosses parity bit
// - Frame width is code width plus parity
// - Ignore parity transmits 0, or odd for 8-bit
// - Airline variant sets transmit idle level
// - Any of four stop chars ends check
// - Either of two start chars begins check
// - Drop list characters return receiver to hunting
// - Sync needs a 16-bit two-character match
`ifndef CSCF_DEFS_SVH
`define CSCF_DEFS_SVH
// ***************************************************************
// Register byte offsets
// ***************************************************************
`define CSCF_OFF_CTRL   8'h00
`define CSCF_OFF_SYNC   8'h04
`define CSCF_OFF_IDLE   8'h08
`define CSCF_OFF_DROP   8'h0C
`define CSCF_OFF_DLIST  8'h10
`define CSCF_OFF_DLIST2 8'h14
`define CSCF_OFF_START  8'h18
`define CSCF_OFF_STOP   8'h1C
`define CSCF_OFF_TXCHR  8'h20
`define CSCF_OFF_STAT   8'h24
// ***************************************************************
// Control field positions and reset values
// ***************************************************************
`define CSCF_CTRL_PAR   2
`define CSCF_CTRL_MSB   4
`define CSCF_CTRL_INV   5
`define CSCF_CTRL_IDLS  6
`define CSCF_CTRL_VAR   7
`define CSCF_CTRL_AIR   8
`define CSCF_CTRL_SEND  10
`define CSCF_CTRL_SLIP  11
`define CSCF_DROP_MASK  8
`define CSCF_RST_CTRL   12'h003
`define CSCF_RST_IDLE   8'hFF
`define CSCF_RST_SYNC   16'hFFFF
`define CSCF_SYNC_BITS  16
`endif

/* File: cscf_pkg.sv */
package cscf_pkg;
  // Receiver framing state
  typedef enum logic [0:0] {CSCF_HUNT, CSCF_INSYNC} cscf_state_t;
  // Parity selection as written to the control register
  typedef enum logic [1:0] {CSCF_PNONE, CSCF_PEVEN, CSCF_PODD, CSCF_PIGN} cscf_par_t;
endpackage : cscf_pkg

/* File: cscf_framer.sv */
// The AHB-Lite interface to the registers and the register addresses were left to the implementer.
`include "cscf_defs.svh"
module cscf_framer
(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [7:0]  haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        line_clk,
  input  wire logic        rx_line,
  output logic             tx_line,
  output logic             cap_valid,
  output logic      [7:0]  cap_char,
  output logic             cap_check,
  output logic             check_expect
);
  // ***************************************************************
  // Bus side registers
  // ***************************************************************
  logic [11:0] ctrl, next_ctrl;        // Code, parity, sense, options
  logic [15:0] sync_pat, next_sync;    // Sync pattern, oldest bit at 15
  logic [7:0]  idle_chr, next_idle;    // Idle character
  logic [15:0] drop_cfg, next_drop;    // Count [2:0], enables [14:8]
  logic [47:0] dlist, next_dlist;      // Six drop characters
  logic [15:0] start_c, next_start;    // Two start characters
  logic [31:0] stop_c, next_stop;      // Four stop characters
  logic [7:0]  tx_chr, next_txchr;     // Character to transmit
  logic        send_tg, next_send_tg;  // Toggle per send request
  logic        slip_tg, next_slip_tg;  // Toggle per slip request
  logic        wr_pend, next_wr_pend;  // Write data phase pending
  logic [7:0]  wr_addr, next_wr_addr;  // Latched write address
  logic [31:0] next_hrdata;            // Read data for data phase
  logic [2:0]  st_q1, st_q2;           // Status back from link side
  logic        addr_ok;                // Valid address phase

  assign hreadyout = 1'b1;  // Registers never insert wait states
  assign hresp     = 1'b0;
  assign addr_ok   = hsel && htrans[1] && hready;

  // Next values of the register file and read mux
  always_comb
  begin
    next_ctrl    = ctrl;
    next_sync    = sync_pat;
    next_idle    = idle_chr;
    next_drop    = drop_cfg;
    next_dlist   = dlist;
    next_start   = start_c;
    next_stop    = stop_c;
    next_txchr   = tx_chr;
    next_send_tg = send_tg;
    next_slip_tg = slip_tg;
    next_wr_pend = addr_ok && hwrite;
    next_wr_addr = addr_ok ? haddr : wr_addr;
    next_hrdata  = hrdata;
    if (wr_pend)
    begin
      unique case (wr_addr)
        `CSCF_OFF_CTRL:
        begin
          // Action bits are pulses, so they are kept out of the stored word
          next_ctrl = hwdata[11:0] & 12'h3FF;
          // Action bits toggle a send or slip request instead of being stored
          if (hwdata[`CSCF_CTRL_SEND])
            next_send_tg = ~send_tg;
          if (hwdata[`CSCF_CTRL_SLIP])
            next_slip_tg = ~slip_tg;
        end
        `CSCF_OFF_SYNC:   next_sync  = hwdata[15:0];
        `CSCF_OFF_IDLE:   next_idle  = hwdata[7:0];
        `CSCF_OFF_DROP:   next_drop  = hwdata[15:0];
        `CSCF_OFF_DLIST:  next_dlist[31:0]  = hwdata;
        `CSCF_OFF_DLIST2: next_dlist[47:32] = hwdata[15:0];
        `CSCF_OFF_START:  next_start = hwdata[15:0];
        `CSCF_OFF_STOP:   next_stop  = hwdata;
        `CSCF_OFF_TXCHR:  next_txchr = hwdata[7:0];
        default:          next_ctrl  = ctrl;  // Unmapped writes vanish
      endcase
    end
    if (addr_ok && !hwrite)
    begin
      unique case (haddr)
        `CSCF_OFF_CTRL:   next_hrdata = {20'h00000, ctrl & 12'h3FF};
        `CSCF_OFF_SYNC:   next_hrdata = {16'h0000, sync_pat};
        `CSCF_OFF_IDLE:   next_hrdata = {24'h000000, idle_chr};
        `CSCF_OFF_DROP:   next_hrdata = {16'h0000, drop_cfg};
        `CSCF_OFF_DLIST:  next_hrdata = dlist[31:0];
        `CSCF_OFF_DLIST2: next_hrdata = {16'h0000, dlist[47:32]};
        `CSCF_OFF_START:  next_hrdata = {16'h0000, start_c};
        `CSCF_OFF_STOP:   next_hrdata = stop_c;
        `CSCF_OFF_TXCHR:  next_hrdata = {24'h000000, tx_chr};
        `CSCF_OFF_STAT:   next_hrdata = {29'h00000000, st_q2};
        default:          next_hrdata = 32'h00000000;
      endcase
    end
  end

  // Register the bus side state
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl     <= `CSCF_RST_CTRL;
      sync_pat <= `CSCF_RST_SYNC;
      idle_chr <= `CSCF_RST_IDLE;
      drop_cfg <= 16'h0000;
      dlist    <= 48'h000000000000;
      start_c  <= 16'h0000;
      stop_c   <= 32'h00000000;
      tx_chr   <= 8'h00;
      send_tg  <= 1'b0;
      slip_tg  <= 1'b0;
      wr_pend  <= 1'b0;
      wr_addr  <= 8'h00;
      hrdata   <= 32'h00000000;
    end
    else
    begin
      ctrl     <= next_ctrl;
      sync_pat <= next_sync;
      idle_chr <= next_idle;
      drop_cfg <= next_drop;
      dlist    <= next_dlist;
      start_c  <= next_start;
      stop_c   <= next_stop;
      tx_chr   <= next_txchr;
      send_tg  <= next_send_tg;
      slip_tg  <= next_slip_tg;
      wr_pend  <= next_wr_pend;
      wr_addr  <= next_wr_addr;
      hrdata   <= next_hrdata;
    end
  end

  // ***************************************************************
  // Crossing into the line clock
  // ***************************************************************
  // Configuration is quasi-static: software changes it only while idle,
  // so a per-bit two-flop pair is enough; the toggles are event crossings
  logic [157:0] cfg_q1, cfg_q2;      // Config synchroniser pair
  logic         lrst_q1, lrst_n;     // Line side reset release
  logic         rx_q1, rx_q2;        // Received bit synchroniser
  logic [11:0]  l_ctrl;
  logic [15:0]  l_sync, l_drop, l_start;
  logic [7:0]   l_idle, l_txchr;
  logic [47:0]  l_dlist;
  logic [31:0]  l_stop;
  logic         l_send, l_slip, send_seen, slip_seen;

  assign {l_ctrl, l_sync, l_idle, l_drop, l_dlist, l_start, l_stop, l_txchr,
          l_send, l_slip} = cfg_q2;

  always_ff @(posedge line_clk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lrst_q1 <= 1'b0;
      lrst_n  <= 1'b0;
      cfg_q1  <= '0;
      cfg_q2  <= '0;
      rx_q1   <= 1'b1;
      rx_q2   <= 1'b1;
    end
    else
    begin
      lrst_q1 <= 1'b1;
      lrst_n  <= lrst_q1;
      cfg_q1  <= {ctrl, sync_pat, idle_chr, drop_cfg, dlist, start_c, stop_c,
                  tx_chr, send_tg, slip_tg};
      cfg_q2  <= cfg_q1;
      rx_q1   <= rx_line;
      rx_q2   <= rx_q1;
    end
  end

  // ***************************************************************
  // Line side decode
  // ***************************************************************
  // Parity of the low n bits of a character; odd asks for odd parity
  function automatic logic cscf_parity(input logic [7:0] d, input logic [3:0] n,
                                       input logic odd);
    logic p;
    p = odd;
    for (int i = 0; i < 8; i++)
      if (i < n)
        p = p ^ d[i];
    return p;
  endfunction : cscf_parity

  cscf_pkg::cscf_par_t par;
  logic [3:0]  code_w, frame_w;      // Code width and frame width
  logic [7:0]  cmask;                // Data bits of the code
  logic        msb_first, inv, never_drop;
  assign par        = cscf_pkg::cscf_par_t'(l_ctrl[`CSCF_CTRL_PAR +: 2]);
  assign code_w     = 4'h5 + {2'b00, l_ctrl[1:0]};
  assign frame_w    = code_w + {3'b000, par != cscf_pkg::CSCF_PNONE};
  assign cmask      = 8'hFF >> (4'h8 - code_w);
  assign msb_first  = l_ctrl[`CSCF_CTRL_MSB];
  assign inv        = l_ctrl[`CSCF_CTRL_INV];
  assign never_drop = (l_drop[2:0] == 3'h0) && (l_drop[14:8] == 7'h00);

  // ***************************************************************
  // Receiver
  // ***************************************************************
  cscf_pkg::cscf_state_t state, next_state;
  logic [15:0] hist, next_hist;      // Last 16 line bits, newest at 0
  logic [8:0]  frm, next_frm;        // Frame under assembly
  logic [3:0]  bcnt, next_bcnt;      // Bits of current frame
  logic [2:0]  dleft, next_dleft;    // Characters left before drop
  logic        dpend, next_dpend;    // Drop counting in progress
  logic        bcc_on, next_bcc_on;  // Inside check bounds
  logic        skip, next_skip;      // Discard one bit for reframing
  logic        next_cap_valid, next_cap_check, next_check_expect;
  logic [7:0]  next_cap_char;
  logic [15:0] pattern;
  logic        bit_in;
  logic [8:0]  fin;
  logic [7:0]  dat;
  logic        is_idle, hit_drop, hit_start, hit_stop;

  assign bit_in  = rx_q2 ^ inv;
  // Idle-sync uses the idle character twice; the fixed pattern otherwise
  assign pattern = l_ctrl[`CSCF_CTRL_IDLS] ? {l_idle, l_idle} : l_sync;
  assign fin     = msb_first ? {frm[7:0], bit_in} : (frm | (9'h001 << bcnt) & {9{bit_in}});
  assign dat     = fin[7:0] & cmask;
  assign is_idle = dat == (l_idle & cmask);
  assign hit_start = (dat == (l_start[7:0] & cmask))
                  || (dat == (l_start[15:8] & cmask));

  // Stop characters and drop list compared one by one
  always_comb
  begin
    hit_stop = 1'b0;
    for (int i = 0; i < 4; i++)
      hit_stop = hit_stop || (dat == (l_stop[8*i +: 8] & cmask));
    // First drop character only inside the bounds, others only outside
    hit_drop = l_drop[8] && bcc_on && (dat == (l_dlist[7:0] & cmask));
    for (int i = 1; i < 6; i++)
      hit_drop = hit_drop || (l_drop[8+i] && !bcc_on
                              && (dat == (l_dlist[8*i +: 8] & cmask)));
    hit_drop = hit_drop || (l_drop[14] && is_idle);
  end

  // Next state of hunting, framing, drop counting and check bounds
  always_comb
  begin
    next_state        = state;
    next_hist         = {hist[14:0], bit_in};
    next_frm          = frm;
    next_bcnt         = bcnt;
    next_dleft        = dleft;
    next_dpend        = dpend;
    next_bcc_on       = bcc_on;
    next_skip         = skip;
    next_cap_valid    = 1'b0;
    next_cap_char     = cap_char;
    next_cap_check    = 1'b0;
    next_check_expect = 1'b0;
    // Slip only LSB-first, parity-free frames: a slip never lands in parity
    if (l_slip != slip_seen && !msb_first && par == cscf_pkg::CSCF_PNONE)
      next_skip = 1'b1;
    unique case (state)
      cscf_pkg::CSCF_HUNT:
      begin
        next_frm  = 9'h000;
        next_bcnt = 4'h0;
        if (next_hist == pattern)
        begin
          next_state  = cscf_pkg::CSCF_INSYNC;
          next_dpend  = 1'b0;
          next_bcc_on = 1'b0;
        end
      end
      cscf_pkg::CSCF_INSYNC:
      begin
        if (skip)
          next_skip = 1'b0;  // Boundary moves one bit later
        else if (bcnt != frame_w - 4'h1)
        begin
          next_frm  = fin;
          next_bcnt = bcnt + 4'h1;
        end
        else
        begin
          next_frm  = 9'h000;
          next_bcnt = 4'h0;
          // Idles are kept only when sync is never dropped
          next_cap_valid = never_drop || !is_idle;
          next_cap_char  = dat;
          next_cap_check = bcc_on;
          if (!bcc_on && hit_start)
            next_bcc_on = 1'b1;
          else if (bcc_on && hit_stop)
          begin
            next_bcc_on       = 1'b0;
            next_check_expect = 1'b1;
          end
          if (!never_drop)
          begin
            if (dpend && dleft == 3'h0)
              next_state = cscf_pkg::CSCF_HUNT;
            else if (dpend)
              next_dleft = dleft - 3'h1;
            else if (hit_drop && l_drop[2:0] == 3'h0)
              next_state = cscf_pkg::CSCF_HUNT;
            else if (hit_drop)
            begin
              next_dpend = 1'b1;
              next_dleft = l_drop[2:0] - 3'h1;
            end
          end
        end
      end
    endcase
  end

  // Register the receiver state
  always_ff @(posedge line_clk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state        <= cscf_pkg::CSCF_HUNT;
      hist         <= 16'h0000;
      frm          <= 9'h000;
      bcnt         <= 4'h0;
      dleft        <= 3'h0;
      dpend        <= 1'b0;
      bcc_on       <= 1'b0;
      skip         <= 1'b0;
      slip_seen    <= 1'b0;
      cap_valid    <= 1'b0;
      cap_char     <= 8'h00;
      cap_check    <= 1'b0;
      check_expect <= 1'b0;
    end
    else
    begin
      state        <= lrst_n ? next_state : cscf_pkg::CSCF_HUNT;
      hist         <= next_hist;
      frm          <= next_frm;
      bcnt         <= next_bcnt;
      dleft        <= next_dleft;
      dpend        <= next_dpend;
      bcc_on       <= next_bcc_on;
      skip         <= next_skip;
      slip_seen    <= l_slip;
      cap_valid    <= next_cap_valid && lrst_n;
      cap_char     <= next_cap_char;
      cap_check    <= next_cap_check;
      check_expect <= next_check_expect;
    end
  end

  // ***************************************************************
  // Transmitter for simulation
  // ***************************************************************
  logic [8:0] tsh, next_tsh;         // Frame being sent
  logic [3:0] tcnt, next_tcnt;       // Bits left to send
  logic       next_tx_line, idle_lvl, tpar;
  // Airline variant picks the idle level for normal sense
  assign idle_lvl = (l_ctrl[`CSCF_CTRL_AIR] ? l_ctrl[`CSCF_CTRL_VAR] : 1'b1) ^ inv;
  // Ignore parity forces 0 below eight bits and odd parity at eight
  always_comb
  begin
    unique case (par)
      cscf_pkg::CSCF_PEVEN: tpar = cscf_parity(l_txchr, code_w, 1'b0);
      cscf_pkg::CSCF_PODD:  tpar = cscf_parity(l_txchr, code_w, 1'b1);
      cscf_pkg::CSCF_PIGN:  tpar = (code_w == 4'h8) && cscf_parity(l_txchr, code_w, 1'b1);
      default:              tpar = 1'b0;
    endcase
  end

  // Load on a new send request, shift out one bit per line clock
  always_comb
  begin
    next_tsh     = tsh;
    next_tcnt    = tcnt;
    next_tx_line = idle_lvl;
    if (tcnt != 4'h0)
    begin
      next_tx_line = (msb_first ? tsh[frame_w - 4'h1] : tsh[0]) ^ inv;
      next_tsh     = msb_first ? {tsh[7:0], 1'b0} : {1'b0, tsh[8:1]};
      next_tcnt    = tcnt - 4'h1;
    end
    else if (l_send != send_seen)
    begin
      next_tsh  = {1'b0, l_txchr & cmask} | ({8'h00, tpar} << code_w);
      next_tcnt = frame_w;
    end
  end

  // Register the transmitter
  always_ff @(posedge line_clk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tsh       <= 9'h000;
      tcnt      <= 4'h0;
      send_seen <= 1'b0;
      tx_line   <= 1'b1;
    end
    else
    begin
      tsh       <= next_tsh;
      tcnt      <= next_tcnt;
      send_seen <= (tcnt == 4'h0) ? l_send : send_seen;
      tx_line   <= next_tx_line;
    end
  end

  // Status back to the bus: in sync, inside bounds, sending
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      st_q1 <= 3'h0;
      st_q2 <= 3'h0;
    end
    else
    begin
      st_q1 <= {tcnt != 4'h0, bcc_on, state == cscf_pkg::CSCF_INSYNC};
      st_q2 <= st_q1;
    end
  end

  // ***************************************************************
  // Checks
  // ***************************************************************
  chk_hunt_no_cap: assert property (@(posedge line_clk) disable iff (!hresetn)
    $past(state) == cscf_pkg::CSCF_HUNT |-> !cap_valid)
    else $error("capture while hunting");
  chk_sync_match: assert property (@(posedge line_clk) disable iff (!hresetn)
    state == cscf_pkg::CSCF_HUNT ##1 state == cscf_pkg::CSCF_INSYNC |-> hist == pattern)
    else $error("sync without pattern");
  chk_never_drop: assert property (@(posedge line_clk) disable iff (!hresetn)
    never_drop && $stable(never_drop) && state == cscf_pkg::CSCF_INSYNC
    |=> state == cscf_pkg::CSCF_INSYNC)
    else $error("sync dropped with drop disabled");
  chk_idle_kept: assert property (@(posedge line_clk) disable iff (!hresetn)
    cap_valid && !$past(never_drop) |-> cap_char != (l_idle & cmask))
    else $error("idle stored");
  chk_frame_cnt: assert property (@(posedge line_clk) disable iff (!hresetn)
    bcnt <= frame_w - 4'h1)
    else $error("frame counter past width");
  chk_stop_end: assert property (@(posedge line_clk) disable iff (!hresetn)
    check_expect |-> !bcc_on && $past(bcc_on, 2))
    else $error("check end outside bounds");
  chk_idle_level: assert property (@(posedge line_clk) disable iff (!hresetn)
    tcnt == 4'h0 && $past(tcnt) == 4'h0 && $stable(idle_lvl) |=> tx_line == $past(idle_lvl))
    else $error("wrong idle level");
  chk_slip_msb: assert property (@(posedge line_clk) disable iff (!hresetn)
    $rose(skip) |-> !msb_first && par == cscf_pkg::CSCF_PNONE)
    else $error("slip on refused format");
endmodule : cscf_framer

/* File: cscf_line_model.sv */
// ***************************************************************
// Far side of the monitored synchronous line
// ***************************************************************
module cscf_line_model
(
  output logic      line_clk,
  output logic      rx_line,
  input  wire logic tx_line
);
  timeunit 1ns;
  timeprecision 100ps;

  // Bit clock runs free: a synchronous line keeps clocking through idles
  initial
  begin
    line_clk = 1'b0;
    rx_line  = 1'b1;
    #5;
    forever #16 line_clk = ~line_clk;
  end

  // One character, bit 0 first; data moves on the falling edge
  task automatic send_char(input logic [7:0] c);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge line_clk);
      rx_line <= c[i];
    end
  endtask : send_char

  // Idle characters are all ones, the usual marking level
  task automatic send_idle(input int n);
    repeat (n) send_char(8'hFF);
  endtask : send_idle

  // Ten transmitted bits from the first zero; a frame must start low
  task automatic get_tx(output logic [9:0] v);
    @(posedge line_clk iff tx_line === 1'b0);
    v[0] = 1'b0;
    for (int i = 1; i < 10; i++)
    begin
      @(posedge line_clk);
      v[i] = tx_line;
    end
  endtask : get_tx
endmodule : cscf_line_model

/* File: cscf_framer_tb.sv */
`include "cscf_defs.svh"
module cscf_framer_tb;
  timeunit 1ns;
  timeprecision 100ps;

  // ***************************************************************
  // Signals
  // ***************************************************************
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [7:0]  haddr, cap_char;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] hwdata, hrdata, rd;
  logic        line_clk, rx_line, tx_line, cap_valid, cap_check, check_expect;
  int          n_mismatch, check_count, cycles, n_expect;
  logic [8:0]  capq[$];  // Captured {in bounds, character}
  logic [9:0]  txv;
  logic [9:0]  txexp[4] = '{10'h3D0, 10'h3A0, 10'h340, 10'h342};
  logic [7:0]  txc[4]   = '{8'h10, 8'h20, 8'h40, 8'h42};

  cscf_framer u_cscf_framer (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .line_clk(line_clk),
    .rx_line(rx_line), .tx_line(tx_line), .cap_valid(cap_valid), .cap_char(cap_char),
    .cap_check(cap_check), .check_expect(check_expect));
  cscf_line_model u_cscf_line_model (.line_clk(line_clk), .rx_line(rx_line),
    .tx_line(tx_line));

  always #2 hclk = ~hclk;

  // Capture log; a pulse lasts one line clock so it is seen once
  always @(posedge line_clk)
  begin
    if (cap_valid === 1'b1)
      capq.push_back({cap_check, cap_char});
    if (check_expect === 1'b1)
      n_expect++;
  end

  // Hang guard, well above the few thousand cycles the run needs
  always @(posedge hclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      n_mismatch++;
      results();
    end
  end

  // ***************************************************************
  // Tasks
  // ***************************************************************
  task automatic results();
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : results

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Address phase held until hready, then the bus goes idle
  task automatic addr_ph(input logic [7:0] a, input logic w);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    htrans <= 2'h2;
    hwrite <= w;
    @(posedge hclk iff hreadyout === 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
  endtask : addr_ph

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    addr_ph(a, 1'b1);
    hwdata <= d;
    @(posedge hclk iff hreadyout === 1'b1);
  endtask : wr

  task automatic rdr(input logic [7:0] a, output logic [31:0] v);
    addr_ph(a, 1'b0);
    @(posedge hclk iff hreadyout === 1'b1);
    v = hrdata;
  endtask : rdr

  task automatic lwait(input int n);
    repeat (n) @(posedge line_clk);
  endtask : lwait

  // Characters back to back, then two idles and time for the last capture
  task automatic send_list(input logic [7:0] q[$]);
    foreach (q[i])
      u_cscf_line_model.send_char(q[i]);
    u_cscf_line_model.send_idle(2);
    lwait(4);
  endtask : send_list

  task automatic sync_bit(input logic exp);
    rdr(`CSCF_OFF_STAT, rd);
    check({31'h0, rd[0]}, {31'h0, exp});
  endtask : sync_bit

  // ***************************************************************
  // Main sequence
  // ***************************************************************
  initial
  begin
    {hclk, hsel, hwrite} = 3'h0;
    {haddr, htrans, hwdata} = '0;
    hsize = 3'h2;
    // Nonblocking so both clock domains see the reset edge at time zero
    hresetn <= 1'b0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    rdr(`CSCF_OFF_CTRL, rd);
    check(rd, 32'h003);
    rdr(`CSCF_OFF_SYNC, rd);
    check(rd, 32'hFFFF);
    rdr(`CSCF_OFF_IDLE, rd);
    check(rd, 32'hFF);
    rdr(8'h3C, rd);
    check(rd, 32'h0);
    check({31'h0, hresp}, 32'h0);
    check({31'h0, hreadyout}, 32'h1);
    sync_bit(1'b0);
    // Start chars 01/02, stop chars 03/17/04/1F, drop on idle
    wr(`CSCF_OFF_START, 32'h0201);
    wr(`CSCF_OFF_STOP, 32'h1F041703);
    wr(`CSCF_OFF_DROP, 32'h4000);
    wr(`CSCF_OFF_SYNC, 32'h6868);                // 0x16 twice, arrival order
    lwait(4);
    send_list('{8'h16, 8'h41});
    check(capq.size(), 0);
    send_list('{8'h16, 8'h16, 8'h41, 8'h42});
    check(capq.size(), 2);
    check(capq[0], 9'h041);
    check(capq[1], 9'h042);
    sync_bit(1'b0);
    capq.delete();
    // Drop list entry 1 ends sync after itself
    wr(`CSCF_OFF_DLIST, 32'h5500);
    wr(`CSCF_OFF_DROP, 32'h0200);
    lwait(4);
    send_list('{8'h16, 8'h16, 8'h41, 8'h55, 8'h42});
    check(capq.size(), 2);
    check(capq[1], 9'h055);
    sync_bit(1'b0);
    capq.delete();
    // Count one: the character after the drop character is the last kept
    wr(`CSCF_OFF_DROP, 32'h0201);
    lwait(4);
    send_list('{8'h16, 8'h16, 8'h55, 8'h42, 8'h43});
    check(capq.size(), 2);
    check(capq[1], 9'h042);
    capq.delete();
    // Check bounds: start char outside, third stop char inside
    wr(`CSCF_OFF_DROP, 32'h4000);
    lwait(4);
    n_expect = 0;
    send_list('{8'h16, 8'h16, 8'h01, 8'h41, 8'h04, 8'h00});
    check(capq[0], 9'h001);
    check(capq[1], 9'h141);
    check(capq[2], 9'h104);
    check(n_expect, 1);
    capq.delete();
    // No drop at all: idles are kept and sync never ends
    wr(`CSCF_OFF_DROP, 32'h0);
    lwait(4);
    send_list('{8'h16, 8'h16, 8'h41});
    check(capq[1], 9'h0FF);
    sync_bit(1'b1);
    wr(`CSCF_OFF_DROP, 32'h4000);
    lwait(20);
    sync_bit(1'b0);
    // Sync on idles with the default idle character
    wr(`CSCF_OFF_DROP, 32'h0);
    wr(`CSCF_OFF_CTRL, 32'h043);
    lwait(40);
    sync_bit(1'b1);
    wr(`CSCF_OFF_CTRL, 32'h003);
    wr(`CSCF_OFF_DROP, 32'h4000);
    lwait(20);
    // Slip asked while hunting drops the first bit after sync
    capq.delete();
    wr(`CSCF_OFF_CTRL, 32'h803);
    lwait(4);
    send_list('{8'h16, 8'h16, 8'h41, 8'h42});
    check(capq[0], 9'h020);
    check(capq[1], 9'h0A1);
    capq.delete();
    // Slip asked with MSB first is lost: framing stays put
    wr(`CSCF_OFF_CTRL, 32'h813);
    lwait(4);
    wr(`CSCF_OFF_CTRL, 32'h003);
    lwait(4);
    send_list('{8'h16, 8'h16, 8'h41});
    check(capq[0], 9'h041);
    // Transmit every code width with ignore parity
    for (int k = 0; k < 4; k++)
    begin
      wr(`CSCF_OFF_CTRL, 32'h00C | k);
      wr(`CSCF_OFF_TXCHR, {24'h0, txc[k]});
      lwait(4);
      wr(`CSCF_OFF_CTRL, 32'h40C | k);
      u_cscf_line_model.get_tx(txv);
      check(txv, txexp[k]);
      lwait(4);
    end
    // Airline idle level for each variant and bit sense
    for (int m = 0; m < 4; m++)
    begin
      wr(`CSCF_OFF_CTRL, 32'h103 | (m[0] << 7) | (m[1] << 5));
      lwait(6);
      check({31'h0, tx_line}, {31'h0, m[0] ^ m[1]});
    end
    wr(`CSCF_OFF_CTRL, 32'h003);
    results();
  end
endmodule : cscf_framer_tb
